// file: design/fts_pkg.sv
package fts_pkg;

	// Organization: 256K words of four 9-bit lanes
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int DATA_W = LANES * LANE_W;
	localparam int SLOT_W = LANE_W + 1;
	localparam int WORD_W = LANES * SLOT_W;
	localparam int DEPTH = 262144;
	localparam int BURST_W = 2;
	localparam int WFIFO_DEPTH = 8;

	// Reset values
	localparam logic [WORD_W-1:0] RST_WORD = 36'h0_0000_0000;
	localparam logic [ADDR_W-1:0] RST_ADDR = 18'h0_0000;
	localparam logic [BURST_W-1:0] RST_BURST = 2'h0;

	// Test access port
	localparam int IR_W = 3;
	localparam int DR_W = 32;
	localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
	localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

	// One write waiting for the array
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] wr_en;
		logic [DATA_W-1:0] data;
		logic [LANES-1:0] par;
	} fts_wr_t;

	localparam int WR_T_W = $bits(fts_wr_t);

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_READ = 2'b01,
		OP_WRITE = 2'b10
	} fts_op_t;

	typedef enum logic [3:0] {
		TAP_RESET = 4'b0000,
		TAP_IDLE = 4'b0001,
		TAP_SEL_DR = 4'b0010,
		TAP_CAP_DR = 4'b0011,
		TAP_SH_DR = 4'b0100,
		TAP_EX1_DR = 4'b0101,
		TAP_PAU_DR = 4'b0110,
		TAP_EX2_DR = 4'b0111,
		TAP_UPD_DR = 4'b1000,
		TAP_SEL_IR = 4'b1001,
		TAP_CAP_IR = 4'b1010,
		TAP_SH_IR = 4'b1011,
		TAP_EX1_IR = 4'b1100,
		TAP_PAU_IR = 4'b1101,
		TAP_EX2_IR = 4'b1110,
		TAP_UPD_IR = 4'b1111
	} fts_tap_t;

	// Lay the selected lanes of a write over a stored word
	function automatic logic [WORD_W-1:0] fts_merge(input logic [WORD_W-1:0] old,
		input fts_wr_t w);
		logic [WORD_W-1:0] r;
		r = old;
		for (int k = 0; k < LANES; k++) begin
			if (w.wr_en[k]) begin
				r[k*SLOT_W +: SLOT_W] = {w.par[k], w.data[k*LANE_W +: LANE_W]};
			end
		end
		return r;
	endfunction

endpackage

// file: design/fts_fifo.sv
`timescale 1ns/1ns
module fts_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Filling side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Draining side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready,
	// Occupancy
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	// Honest flags straight from the occupancy count
	assign o_in_ready = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data = store[rd_ptr];
	assign o_count = count;
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// Pointers wrap naturally; depth must be a power of two
	always_comb begin
		next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage carries no reset, it is only read where count says valid
	always_ff @(posedge i_mclk) begin
		if (push) begin
			store[wr_ptr] <= i_in_data;
		end
	end

endmodule

// file: design/fts_sram.sv
`timescale 1ns/1ns
// Functional notes
// - Inputs sampled on rising clock edge
// - Clock qualifier high freezes the access pipeline; buffered writes still drain
// - Reads and writes back to back, no gaps
// - Write strobe plus per-lane low write selects
// - Writes finish internally, no external pulse
// - Three chip selects must all be active
// - Output enable gates drivers asynchronously
// - Drivers off during write data phase
// - Turnaround handled internally without output enable
// - Bursts linear or interleaved by order input
// - Low power on sleep or deselect
// - Boundary-scan test access port provided
module fts_sram
	import fts_pkg::*;
#(
	parameter logic [DR_W-1:0] IDCODE = 32'h0000_0001 // Arbitrary value
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Controller address and control
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_clock_qualify_n,
	input wire logic i_write_n,
	input wire logic [LANES-1:0] i_byte_lane_write_sel_n,
	input wire logic i_chip_sel_a_n,
	input wire logic i_chip_sel_b,
	input wire logic i_chip_sel_c_n,
	input wire logic i_burst_advance_or_load,
	input wire logic i_burst_order,
	input wire logic i_out_enable_n,
	input wire logic i_sleep_request,
	// Data bus
	input wire logic [DATA_W-1:0] i_dq,
	input wire logic [LANES-1:0] i_lane_parity_bits,
	output logic [DATA_W-1:0] o_dq,
	output logic [LANES-1:0] o_lane_parity_bits,
	output logic o_dq_oe,
	// Status
	output logic o_low_power,
	// Test access port
	input wire logic i_tap_clk,
	input wire logic i_tap_mode_sel,
	input wire logic i_tap_data_in,
	output logic o_tap_data_out,
	output logic o_tap_data_oe
);

	////////////////////////////////////////////////////////////////////////
	// Reset and pin synchronisers

	logic rst_s1;
	logic rst_n;
	logic sleep_s1;
	logic sleep_s2;
	logic [2:0] tck_s;
	logic [1:0] tms_s;
	logic [1:0] tdi_s;

	// Reset enters asynchronously, is released through two flops
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Sleep and the scan pins come from outside the clock domain
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_s1 <= 1'b0;
			sleep_s2 <= 1'b0;
			tck_s <= 3'h0;
			tms_s <= 2'h3;
			tdi_s <= 2'h0;
		end else begin
			sleep_s1 <= i_sleep_request;
			sleep_s2 <= sleep_s1;
			tck_s <= {tck_s[1:0], i_tap_clk};
			tms_s <= {tms_s[0], i_tap_mode_sel};
			tdi_s <= {tdi_s[0], i_tap_data_in};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write buffer between the data phase and the array

	fts_wr_t wr_push;
	fts_wr_t wr_head;
	logic wr_push_valid;
	logic wr_in_ready;
	logic wr_head_valid;
	logic wr_drain;
	logic [$clog2(WFIFO_DEPTH):0] wr_count;

	// Draining stalls while asleep, so up to two writes can wait in the buffer
	assign wr_drain = ~sleep_s2;

	fts_fifo #(
		.WIDTH(WR_T_W),
		.DEPTH(WFIFO_DEPTH)
	) u_wr_fifo (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_in_valid(wr_push_valid),
		.i_in_data(wr_push),
		.o_in_ready(wr_in_ready),
		.o_out_valid(wr_head_valid),
		.o_out_data(wr_head),
		.i_out_ready(wr_drain),
		.o_count(wr_count)
	);

	////////////////////////////////////////////////////////////////////////
	// Access pipeline

	fts_op_t op;
	fts_op_t next_op;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] next_base;
	logic [BURST_W-1:0] cnt;
	logic [BURST_W-1:0] next_cnt;
	logic [LANES-1:0] lanes;
	logic [LANES-1:0] next_lanes;
	logic [ADDR_W-1:0] op_addr;
	logic [ADDR_W-1:0] next_op_addr;
	logic [WORD_W-1:0] dq_word;
	logic [WORD_W-1:0] next_dq_word;
	logic dq_drive;
	logic next_dq_drive;
	logic low_power;
	logic next_low_power;
	logic cycle_en;
	logic selected;
	logic [WORD_W-1:0] array [DEPTH];

	// Only one pending write may sit ahead of a read, else bypass breaks
	assign cycle_en = ~i_clock_qualify_n & wr_in_ready & (wr_count < 2);

	// All three selects, and the part must be awake
	assign selected = ~i_chip_sel_a_n & i_chip_sel_b & ~i_chip_sel_c_n & ~sleep_s2;

	// Data phase of last cycle's write is captured on this edge
	always_comb begin
		wr_push.addr = op_addr;
		wr_push.wr_en = lanes;
		wr_push.data = i_dq;
		wr_push.par = i_lane_parity_bits;
		wr_push_valid = cycle_en & (op == OP_WRITE);
	end

	// Decode, burst addressing and flow-through read
	always_comb begin
		logic [BURST_W-1:0] low;
		fts_wr_t head_bp;
		low = RST_BURST;
		head_bp = wr_head;
		next_op = op;
		next_base = base;
		next_cnt = cnt;
		next_lanes = lanes;
		next_op_addr = op_addr;
		next_dq_word = dq_word;
		next_dq_drive = dq_drive;
		next_low_power = sleep_s2 | (op == OP_IDLE);
		if (cycle_en) begin
			if (!i_burst_advance_or_load) begin
				next_op = selected ? (i_write_n ? OP_READ : OP_WRITE) : OP_IDLE;
				next_base = i_addr;
				next_cnt = RST_BURST;
			end else begin
				next_op = sleep_s2 ? OP_IDLE : op;
				next_cnt = cnt + BURST_W'(1);
			end
			next_lanes = ~i_byte_lane_write_sel_n;
			// Linear adds, interleaved flips the low address bits
			if (i_burst_order) begin
				low = next_base[BURST_W-1:0] ^ next_cnt;
			end else begin
				low = next_base[BURST_W-1:0] + next_cnt;
			end
			next_op_addr = {next_base[ADDR_W-1:BURST_W], low};
			// Oldest first: array, buffered write, write landing now
			next_dq_word = array[next_op_addr];
			head_bp.wr_en = (wr_head_valid && wr_head.addr == next_op_addr) ?
				wr_head.wr_en : '0;
			next_dq_word = fts_merge(next_dq_word, head_bp);
			if (wr_push_valid && op_addr == next_op_addr) begin
				next_dq_word = fts_merge(next_dq_word, wr_push);
			end
			// Drivers follow the operation, no output enable needed
			next_dq_drive = (next_op == OP_READ);
			next_low_power = sleep_s2 | (next_op == OP_IDLE);
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			op <= OP_IDLE;
			base <= RST_ADDR;
			cnt <= RST_BURST;
			lanes <= '0;
			op_addr <= RST_ADDR;
			dq_word <= RST_WORD;
			dq_drive <= 1'b0;
			low_power <= 1'b1;
		end else begin
			op <= next_op;
			base <= next_base;
			cnt <= next_cnt;
			lanes <= next_lanes;
			op_addr <= next_op_addr;
			dq_word <= next_dq_word;
			dq_drive <= next_dq_drive;
			low_power <= next_low_power;
		end
	end

	// Self-timed array write, one buffered word per awake cycle
	always_ff @(posedge i_mclk) begin
		if (wr_head_valid && wr_drain) begin
			array[wr_head.addr] <= fts_merge(array[wr_head.addr], wr_head);
		end
	end

	// Unpack lanes into data and parity
	always_comb begin
		for (int k = 0; k < LANES; k++) begin
			o_dq[k*LANE_W +: LANE_W] = dq_word[k*SLOT_W +: LANE_W];
			o_lane_parity_bits[k] = dq_word[k*SLOT_W + LANE_W];
		end
	end

	// Output enable acts without the clock, so it bypasses the flop
	assign o_dq_oe = dq_drive & ~i_out_enable_n & ~sleep_s2;
	assign o_low_power = low_power;

	////////////////////////////////////////////////////////////////////////
	// Test access port, stepped by the sampled scan clock

	fts_tap_t tap;
	fts_tap_t next_tap;
	logic [IR_W-1:0] ir;
	logic [IR_W-1:0] next_ir;
	logic [IR_W-1:0] ir_sh;
	logic [IR_W-1:0] next_ir_sh;
	logic [DR_W-1:0] dr;
	logic [DR_W-1:0] next_dr;
	logic tdo;
	logic next_tdo;
	logic tdo_oe;
	logic next_tdo_oe;
	logic tck_rise;
	logic tck_fall;
	logic tms;
	logic tdi;

	assign tck_rise = tck_s[1] & ~tck_s[2];
	assign tck_fall = ~tck_s[1] & tck_s[2];
	assign tms = tms_s[1];
	assign tdi = tdi_s[1];

	// Standard sixteen-state controller; boundary cells are not modelled
	always_comb begin
		next_tap = tap;
		next_ir = ir;
		next_ir_sh = ir_sh;
		next_dr = dr;
		next_tdo = tdo;
		next_tdo_oe = tdo_oe;
		if (tck_rise) begin
			unique case (tap)
				TAP_RESET: next_tap = tms ? TAP_RESET : TAP_IDLE;
				TAP_IDLE: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_DR: next_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
				TAP_CAP_DR: next_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
				TAP_SH_DR: next_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
				TAP_EX1_DR: next_tap = tms ? TAP_UPD_DR : TAP_PAU_DR;
				TAP_PAU_DR: next_tap = tms ? TAP_EX2_DR : TAP_PAU_DR;
				TAP_EX2_DR: next_tap = tms ? TAP_UPD_DR : TAP_SH_DR;
				TAP_UPD_DR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_IR: next_tap = tms ? TAP_RESET : TAP_CAP_IR;
				TAP_CAP_IR: next_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
				TAP_SH_IR: next_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
				TAP_EX1_IR: next_tap = tms ? TAP_UPD_IR : TAP_PAU_IR;
				TAP_PAU_IR: next_tap = tms ? TAP_EX2_IR : TAP_PAU_IR;
				TAP_EX2_IR: next_tap = tms ? TAP_UPD_IR : TAP_SH_IR;
				TAP_UPD_IR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
			endcase
			unique case (tap)
				TAP_RESET: next_ir = IR_IDCODE;
				TAP_CAP_IR: next_ir_sh = IR_CAPTURE;
				TAP_SH_IR: next_ir_sh = {tdi, ir_sh[IR_W-1:1]};
				TAP_UPD_IR: next_ir = ir_sh;
				TAP_CAP_DR: next_dr = (ir == IR_IDCODE) ? IDCODE : '0;
				TAP_SH_DR: begin
					// Any code other than identify acts as one-bit bypass
					if (ir == IR_IDCODE) begin
						next_dr = {tdi, dr[DR_W-1:1]};
					end else begin
						next_dr = {{(DR_W-1){1'b0}}, tdi};
					end
				end
				default: next_dr = dr;
			endcase
		end
		// Data out changes on the falling scan edge
		if (tck_fall) begin
			next_tdo = (tap == TAP_SH_IR) ? ir_sh[0] : dr[0];
			next_tdo_oe = (tap == TAP_SH_IR) | (tap == TAP_SH_DR);
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			tap <= TAP_RESET;
			ir <= IR_IDCODE;
			ir_sh <= '0;
			dr <= '0;
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tap <= next_tap;
			ir <= next_ir;
			ir_sh <= next_ir_sh;
			dr <= next_dr;
			tdo <= next_tdo;
			tdo_oe <= next_tdo_oe;
		end
	end

	assign o_tap_data_out = tdo;
	assign o_tap_data_oe = tdo_oe;

endmodule

// file: tb/fts_sram_chk.sv
`timescale 1ns/1ns
module fts_sram_chk
	import fts_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Controller inputs
	input wire logic i_clock_qualify_n,
	input wire logic i_write_n,
	input wire logic i_chip_sel_a_n,
	input wire logic i_chip_sel_b,
	input wire logic i_chip_sel_c_n,
	input wire logic i_burst_advance_or_load,
	input wire logic i_out_enable_n,
	input wire logic i_sleep_request,
	// Device outputs
	input wire logic [DATA_W-1:0] o_dq,
	input wire logic o_dq_oe,
	input wire logic o_low_power
);
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);

	// All three selects active
	logic sel;
	assign sel = !i_chip_sel_a_n && i_chip_sel_b && !i_chip_sel_c_n;

	////////////////////////////////
	// Steps of an operation on the pins
	sequence s_load;
		!i_clock_qualify_n && !i_burst_advance_or_load;
	endsequence
	sequence s_wr_load;
		s_load ##0 (sel && !i_write_n);
	endsequence
	sequence s_rd_load;
		s_load ##0 (sel && i_write_n);
	endsequence
	// Sleep passes a synchroniser, so let it settle first
	sequence s_awake;
		!i_sleep_request [*4];
	endsequence
	sequence s_asleep;
		(i_sleep_request && !i_clock_qualify_n) [*5];
	endsequence

	////////////////////////////////
	chk_wr_drv_off: assert property (s_wr_load |=> !o_dq_oe)
		else $error("drivers on in write data phase");
	chk_burst_wr_off: assert property (
		s_wr_load ##1 (!i_clock_qualify_n && i_burst_advance_or_load) |=> !o_dq_oe)
		else $error("drivers on in burst write");
	chk_read_drive: assert property (
		s_awake ##0 s_rd_load |=> o_dq_oe || i_out_enable_n)
		else $error("read not driven after its edge");
	chk_turn_around: assert property (
		s_awake ##0 s_wr_load ##1 s_rd_load |=> o_dq_oe || i_out_enable_n)
		else $error("read after write not driven");
	chk_oe_async: assert property (i_out_enable_n |-> !o_dq_oe)
		else $error("drivers on with output enable off");
	chk_stall_hold: assert property (i_clock_qualify_n |=> $stable(o_dq))
		else $error("read data moved on a stalled edge");
	chk_desel_idle: assert property (
		s_load ##0 !sel |=> o_low_power && !o_dq_oe)
		else $error("deselected load not idle");
	chk_sleep_power: assert property (s_asleep |-> o_low_power && !o_dq_oe)
		else $error("sleep not in low power");
endmodule

bind fts_sram fts_sram_chk u_fts_sram_chk (
	.i_mclk,
	.i_rst_b,
	.i_clock_qualify_n,
	.i_write_n,
	.i_chip_sel_a_n,
	.i_chip_sel_b,
	.i_chip_sel_c_n,
	.i_burst_advance_or_load,
	.i_out_enable_n,
	.i_sleep_request,
	.o_dq,
	.o_dq_oe,
	.o_low_power
);

// file: tb/fts_ctl.sv
`timescale 1ns/1ns
module fts_ctl
	import fts_pkg::*;
(
	// Clock
	input wire logic i_mclk,
	// Address, lane enables, write data
	output fts_wr_t o_bus,
	// Control at the memory's levels
	output logic o_clock_qualify_n,
	output logic o_write_n,
	output logic o_chip_sel_a_n,
	output logic o_chip_sel_b,
	output logic o_chip_sel_c_n,
	output logic o_burst_advance_or_load
);
	logic wpend = 1'b0;
	logic [DATA_W+LANES-1:0] wdat;

	// Stalled and deselected until the first cycle
	initial begin
		o_bus = 58'h0;
		o_clock_qualify_n = 1'b1;
		o_write_n = 1'b1;
		o_chip_sel_a_n = 1'b1;
		o_chip_sel_b = 1'b0;
		o_chip_sel_c_n = 1'b1;
		o_burst_advance_or_load = 1'b0;
	end

	////////////////////////////////
	// One bus cycle; write data follows its address by one enabled edge
	task automatic cyc(input logic q_n, ld, w, input logic [2:0] sel,
		input logic [ADDR_W-1:0] a, input logic [LANES-1:0] en,
		input logic [DATA_W+LANES-1:0] d);
		@(posedge i_mclk);
		o_clock_qualify_n <= q_n;
		o_burst_advance_or_load <= ~ld;
		o_write_n <= ~w;
		o_chip_sel_a_n <= ~sel[0];
		o_chip_sel_b <= sel[1];
		o_chip_sel_c_n <= ~sel[2];
		o_bus.addr <= a;
		o_bus.wr_en <= en;
		// Lines not carrying write data keep changing, never the old value
		{o_bus.par, o_bus.data} <= wpend ? wdat : ~{o_bus.par, o_bus.data};
		if (!q_n) begin
			wpend = w && (sel == 3'h7);
			wdat = d;
		end
	endtask
endmodule

// file: tb/fts_sram_tb.sv
`timescale 1ns/1ns
module fts_sram_tb
	import fts_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic oe_n = 1'b0;
	logic sleep = 1'b0;
	logic order = 1'b0;
	fts_wr_t bus;
	wire q_n;
	wire wr_n;
	wire ca_n;
	wire cb;
	wire cc_n;
	wire adv;
	logic [DATA_W-1:0] dq;
	logic [LANES-1:0] par;
	logic dq_oe;
	logic [1:0] ek = 2'h0;
	logic [1:0] ck = 2'h0;
	logic [DATA_W+LANES-1:0] ee;
	logic [DATA_W+LANES-1:0] ce;
	logic [DATA_W+LANES-1:0] mem [int];
	// Scan pins; the pin idles high on mode select
	logic tck = 1'b0;
	logic tms = 1'b1;
	wire tdo;
	wire tdo_oe;
	// Identity word loaded into the part; the value is arbitrary
	localparam logic [DR_W-1:0] ID = 32'h2c5a_93e7;
	int n_mismatch = 0;
	int compares = 0;
	int cyc_n = 0;

	initial forever #5 i_mclk = ~i_mclk;

	fts_ctl u_fts_ctl (
		.i_mclk(i_mclk),
		.o_bus(bus),
		.o_clock_qualify_n(q_n),
		.o_write_n(wr_n),
		.o_chip_sel_a_n(ca_n),
		.o_chip_sel_b(cb),
		.o_chip_sel_c_n(cc_n),
		.o_burst_advance_or_load(adv)
	);

	// Data wire: the memory wins while it drives
	fts_sram #(
		.IDCODE(ID)
	) u_fts_sram (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_addr(bus.addr),
		.i_clock_qualify_n(q_n),
		.i_write_n(wr_n),
		.i_byte_lane_write_sel_n(~bus.wr_en),
		.i_chip_sel_a_n(ca_n),
		.i_chip_sel_b(cb),
		.i_chip_sel_c_n(cc_n),
		.i_burst_advance_or_load(adv),
		.i_burst_order(order),
		.i_out_enable_n(oe_n),
		.i_sleep_request(sleep),
		.i_dq(dq_oe ? dq : bus.data),
		.i_lane_parity_bits(dq_oe ? par : bus.par),
		.o_dq(dq),
		.o_lane_parity_bits(par),
		.o_dq_oe(dq_oe),
		.o_low_power(),
		.i_tap_clk(tck),
		.i_tap_mode_sel(tms),
		.i_tap_data_in(1'b0),
		.o_tap_data_out(tdo),
		.o_tap_data_oe(tdo_oe)
	);

	////////////////////////////////
	// Expectation reaches the check one edge later; watchdog
	always @(posedge i_mclk) begin
		ck <= ek;
		ce <= ee;
		cyc_n <= cyc_n + 1;
		if (cyc_n == 1000) begin
			n_mismatch++;
			$display("[ERR] %0t watchdog expired", $time);
			report_and_stop();
		end
	end

	// Judge at the falling edge, when outputs have settled
	always @(negedge i_mclk) begin
		if (ck != 2'h0) begin
			compares++;
			if (dq_oe !== (ck == 2'h1) || (ck == 2'h1 && {par, dq} !== ce)) begin
				n_mismatch++;
				$display("[ERR] %0t read word or driver state wrong", $time);
			end
		end
	end

	task automatic report_and_stop();
		$display("Compares %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////
	// k: 0 nothing, 1 read word e, 2 drivers off; a stall keeps the last
	task automatic op(input logic q_n, ld, w, input logic [2:0] sel,
		input logic [ADDR_W-1:0] a, input logic [LANES-1:0] en,
		input logic [DATA_W+LANES-1:0] e, input logic [1:0] k);
		u_fts_ctl.cyc(q_n, ld, w, sel, a, en, e);
		if (!q_n) begin
			ek <= k;
			ee <= e;
		end
	endtask

	task automatic hold();
		op(1'b1, 1'b0, 1'b1, 3'h0, 18'h3ffff, 4'h5, 36'h0, 2'h0);
	endtask

	task automatic idle();
		op(1'b0, 1'b1, 1'b0, 3'h0, 18'h0, 4'h0, 36'h0, 2'h2);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		op(1'b0, 1'b1, 1'b0, 3'h7, a, 4'h0, mem[a], 2'h1);
	endtask

	// Model keeps only the selected lanes, parity with its byte
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] en,
		input logic [DATA_W+LANES-1:0] d);
		for (int k = 0; k < LANES; k++) begin
			if (en[k]) begin
				mem[a][LANE_W*k +: LANE_W] = d[LANE_W*k +: LANE_W];
				mem[a][DATA_W+k] = d[DATA_W+k];
			end
		end
		op(1'b0, 1'b1, 1'b1, 3'h7, a, en, d, 2'h2);
	endtask

	////////////////////////////////
	task automatic t_b2b();
		wr(18'h00010, 4'hf, 36'h1_1234_5678);
		rd(18'h00010);
		wr(18'h00011, 4'hf, 36'ha_cafe_f00d);
		wr(18'h00010, 4'hf, 36'h5_a5a5_0f0f);
		rd(18'h00011);
		rd(18'h00010);
	endtask

	task automatic t_lanes();
		wr(18'h00020, 4'hf, 36'h0);
		for (int k = 0; k < LANES; k++) begin
			wr(18'h00020, 4'h1 << k, 36'hf_ffff_ffff);
			rd(18'h00020);
		end
	endtask

	// Bursts of four from an odd start, then single reads at known places
	task automatic t_burst();
		logic [1:0] seq [2][4] = '{'{2'h1, 2'h2, 2'h3, 2'h0}, '{2'h1, 2'h0, 2'h3, 2'h2}};
		for (int o = 0; o < 2; o++) begin
			order <= o[0];
			for (int i = 0; i < 4; i++) begin
				op(1'b0, i == 0, 1'b1, 3'h7, 18'h00031, 4'hf, {4'hc, 28'h0, o[1:0], i[1:0]}, 2'h2);
			end
			for (int i = 0; i < 4; i++) begin
				op(1'b0, i == 0, 1'b0, 3'h7, 18'h00031, 4'h0, {4'hc, 28'h0, o[1:0], i[1:0]}, 2'h1);
			end
			for (int i = 0; i < 4; i++) begin
				op(1'b0, 1'b1, 1'b0, 3'h7, {16'h000c, seq[o][i]}, 4'h0, {4'hc, 28'h0, o[1:0], i[1:0]}, 2'h1);
			end
		end
	endtask

	task automatic t_freeze();
		rd(18'h00011);
		repeat (3) hold();
		wr(18'h00040, 4'hf, 36'h7_7777_0000);
		repeat (2) hold();
		rd(18'h00040);
	endtask

	task automatic t_desel();
		for (int k = 0; k < 3; k++) begin
			op(1'b0, 1'b1, 1'b1, 3'h7 ^ (3'h1 << k), 18'h00010, 4'hf, 36'h0, 2'h2);
			rd(18'h00010);
		end
	endtask

	// Output enable switches drivers while the stalled read word stands
	task automatic t_oe();
		rd(18'h00011);
		hold();
		ek <= 2'h2;
		hold();
		oe_n <= 1'b1;
		ek <= 2'h1;
		hold();
		oe_n <= 1'b0;
		hold();
	endtask

	task automatic t_sleep();
		sleep <= 1'b1;
		repeat (6) idle();
		op(1'b0, 1'b1, 1'b0, 3'h7, 18'h00011, 4'h0, 36'h0, 2'h2);
		idle();
		sleep <= 1'b0;
		repeat (5) idle();
		rd(18'h00011);
	endtask

	// One slow scan clock pulse; the part samples its scan pins through flops,
	// so each phase lasts four clocks and data out is settled on return
	task automatic scan(input logic m);
		tms <= m;
		repeat (4) @(posedge i_mclk);
		tck <= 1'b1;
		repeat (4) @(posedge i_mclk);
		tck <= 1'b0;
		repeat (4) @(posedge i_mclk);
	endtask

	// Walk to the data shift state and read the identity word bit by bit
	task automatic t_scan();
		scan(1'b0);
		scan(1'b1);
		scan(1'b0);
		compares++;
		if (tdo_oe !== 1'b0) begin
			n_mismatch++;
			$display("[ERR] %0t scan output driven before shift", $time);
		end
		for (int i = 0; i < DR_W; i++) begin
			scan(1'b0);
			compares++;
			if (tdo !== ID[i] || tdo_oe !== 1'b1) begin
				n_mismatch++;
				$display("[ERR] %0t identity bit %0d wrong", $time, i);
			end
		end
		scan(1'b1);
		compares++;
		if (tdo_oe !== 1'b0) begin
			n_mismatch++;
			$display("[ERR] %0t scan output driven after shift", $time);
		end
	endtask

	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		repeat (3) hold();
		t_b2b();
		t_lanes();
		t_burst();
		t_freeze();
		t_desel();
		t_oe();
		t_sleep();
		repeat (2) idle();
		t_scan();
		report_and_stop();
	end
endmodule
